// ===== core/dag_event_status.sv
// Sticky write-one-to-clear event flags, mask and level interrupt.
// Assumes set pulses and writes are synchronous to the clock.

`default_nettype none

module dag_event_status #(
	parameter int N = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [N-1:0] evSet,
	input  wire logic         clrWr,
	input  wire logic [N-1:0] clrData,
	input  wire logic         maskWr,
	input  wire logic [N-1:0] maskData,
	output logic      [N-1:0] status,
	output logic      [N-1:0] mask,
	output logic              irq
);
	import dag_pkg::*;

	// Set wins over a clear in the same cycle so no event is lost
	for (genvar i = 0; i < N; i++) begin : g_flag
		always_ff @(posedge clk) begin
			if (rst)
				status[i] <= STATUS_RST[i];
			else if (ce)
				status[i] <= evSet[i] | (status[i] & ~(clrWr & clrData[i]));
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			mask <= MASK_RST[N-1:0];
		else if (ce && maskWr)
			mask <= maskData;
	end

	always_ff @(posedge clk) begin
		if (rst)
			irq <= 1'b0;
		else if (ce)
			irq <= |(status & mask);
	end

endmodule

`default_nettype wire

// ===== core/dag_gate.sv
// Access gate for the debug register map seen from the debug port.
// Assumes single-cycle request pulses, live power and lock conditions,
// and a plain software register port with read data one cycle later.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.

`default_nettype none

module dag_gate (
	input  wire logic                       ref_clk,
	input  wire logic                       rst,
	input  wire logic                       ce,
	input  wire logic [dag_pkg::REG_AW-1:0] regAddr,
	input  wire logic [31:0]                regWdata,
	input  wire logic                       regWr,
	input  wire logic                       regRd,
	output logic      [31:0]                regRdata,
	input  wire logic                       dbgReq,
	input  wire logic [dag_pkg::PORT_W-1:0] debugPortAddress,
	input  wire logic                       dbgWrite,
	input  wire logic                       dbgSwEnable,
	input  wire logic                       dbgPrivileged,
	input  wire logic                       dbgLogicPowered,
	input  wire logic                       corePoweredUp,
	input  wire logic                       stickyPowerdown,
	input  wire logic                       osLockSet,
	output logic                            respValid,
	output dag_pkg::dag_outcome_t           respOutcome,
	output logic                            respSlvErr,
	output logic                            respAbort,
	output logic                            respForward,
	output logic                            respWriteEn,
	output logic                            respReadZero,
	output logic                            irq
);
	import dag_pkg::*;

	// ----------------------------------------------------------------
	// Decision
	// ----------------------------------------------------------------
	logic [CTL_W-1:0]  ctrl;
	logic [EV_N-1:0]   status;
	logic [EV_N-1:0]   mask;
	logic [EV_N-1:0]   evSet;
	dag_outcome_t      decided;
	dag_class_t        cls;
	logic [ADDR_W-1:0] offs;
	logic              isExt;

	assign offs  = debugPortAddress[ADDR_W-1:0];
	assign isExt = debugPortAddress[EXT_BIT];

	// Purely combinational so the answer lands the cycle after the request
	dag_outcome_decode u_decode (
		.addr            (offs),
		.isExt           (isExt),
		.swEnable        (dbgSwEnable),
		.privileged      (dbgPrivileged),
		.dbgLogicPowered (dbgLogicPowered),
		.corePoweredUp   (corePoweredUp),
		.stickyPowerdown (stickyPowerdown),
		.osLockSet       (osLockSet),
		.memMapPresent   (ctrl[CTL_MEMMAP]),
		.singlePower     (ctrl[CTL_SINGLE]),
		.osSaveRestore   (ctrl[CTL_OSSR]),
		.outcome         (decided),
		.cls             (cls)
	);

	// ----------------------------------------------------------------
	// Response stage
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst)
			respValid <= 1'b0;
		else if (ce)
			respValid <= dbgReq;
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			respOutcome <= OUT_OK;
		else if (ce && dbgReq)
			respOutcome <= decided;
	end

	// Error answers drop the write; read data is left to the receiver
	always_ff @(posedge ref_clk) begin
		if (rst)
			respSlvErr <= 1'b0;
		else if (ce)
			respSlvErr <= dbgReq && decided == OUT_ERROR;
	end

	// Ignore or abort never reaches the processor; ctrl picks which
	always_ff @(posedge ref_clk) begin
		if (rst)
			respAbort <= 1'b0;
		else if (ce)
			respAbort <= dbgReq && decided == OUT_IGABT && ctrl[CTL_ABORT];
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			respForward <= 1'b0;
		else if (ce)
			respForward <= dbgReq && decided == OUT_OK;
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			respWriteEn <= 1'b0;
		else if (ce)
			respWriteEn <= dbgReq && dbgWrite && decided == OUT_OK
				&& !dag_read_only(offs);
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			respReadZero <= 1'b0;
		else if (ce)
			respReadZero <= dbgReq && !dbgWrite && decided == OUT_RAZWI;
	end

	// ----------------------------------------------------------------
	// Events and interrupt
	// ----------------------------------------------------------------
	always_comb begin
		evSet           = '0;
		evSet[EV_ERROR] = dbgReq && decided == OUT_ERROR;
		evSet[EV_IGABT] = dbgReq && (decided == OUT_IGABT || decided == OUT_NPOSS);
		evSet[EV_UNP]   = dbgReq && decided == OUT_UNP;
		evSet[EV_NOACC] = dbgReq && cls == CLS_NOACC;
	end

	dag_event_status #(.N(EV_N)) u_events (
		.clk      (ref_clk),
		.rst      (rst),
		.ce       (ce),
		.evSet    (evSet),
		.clrWr    (regWr && regAddr == REG_STATUS),
		.clrData  (regWdata[EV_N-1:0]),
		.maskWr   (regWr && regAddr == REG_MASK),
		.maskData (regWdata[EV_N-1:0]),
		.status   (status),
		.mask     (mask),
		.irq      (irq)
	);

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	// Changing the scheme mid-traffic is legal but alters the next decision
	always_ff @(posedge ref_clk) begin
		if (rst)
			ctrl <= CTRL_RST;
		else if (ce && regWr && regAddr == REG_CTRL)
			ctrl <= regWdata[CTL_W-1:0];
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			regRdata <= 32'h0000_0000;
		end else if (ce) begin
			regRdata <= 32'h0000_0000;
			if (regRd) begin
				case (regAddr)
					REG_CTRL:   regRdata[CTL_W-1:0] <= ctrl;
					REG_STATUS: regRdata[EV_N-1:0] <= status;
					REG_MASK:   regRdata[EV_N-1:0] <= mask;
					REG_STATE:  regRdata[ST_OUT_LSB+2:0] <= {respOutcome, osLockSet,
						stickyPowerdown, corePoweredUp, dbgLogicPowered};
					default:    regRdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic pathOk;
	logic sepPwr;
	assign pathOk = dbgLogicPowered && (!ctrl[CTL_MEMMAP] || isExt
		|| (dbgSwEnable && dbgPrivileged));
	assign sepPwr = !ctrl[CTL_SINGLE];

	sequence reqTaken;
		ce && dbgReq;
	endsequence

	sequence errFlagged;
		ce && dbgReq && decided == OUT_ERROR && mask[EV_ERROR];
	endsequence

	unpowered_ignore_a: assert property (
		reqTaken and (sepPwr && !dbgLogicPowered)
		|=> respOutcome == OUT_IGABT && !respForward && !respSlvErr)
		else $error("unpowered access not ignored");

	no_mm_cond_a: assert property (
		reqTaken and (!ctrl[CTL_MEMMAP] && sepPwr && dbgLogicPowered
		&& !dbgSwEnable && cls == CLS_ALWAYS)
		|=> respForward)
		else $error("software enable affected access without memory port");

	ext_implied_a: assert property (
		reqTaken and (!ctrl[CTL_MEMMAP] && !isExt && dbgLogicPowered && sepPwr
		&& cls == CLS_MGMT)
		|=> respOutcome == OUT_OK)
		else $error("access not treated as external");

	rsvd_razwi_a: assert property (
		reqTaken and (sepPwr && pathOk && cls == CLS_RSVD)
		|=> respOutcome == ((corePoweredUp && !stickyPowerdown && !osLockSet)
			? OUT_RAZWI : OUT_UNP))
		else $error("reserved location outcome wrong");

	other_err_a: assert property (
		reqTaken and (sepPwr && pathOk && cls == CLS_OTHER
		&& (!corePoweredUp || stickyPowerdown || osLockSet))
		|=> respSlvErr && respOutcome == OUT_ERROR)
		else $error("other debug register not errored");

	mgmt_ok_a: assert property (
		reqTaken and (pathOk && corePoweredUp && cls == CLS_MGMT)
		|=> respForward ##0 respValid)
		else $error("management register blocked");

	save_restore_a: assert property (
		reqTaken and (sepPwr && pathOk && cls == CLS_OS_SAVE_RESTORE_REG)
		|=> respOutcome == ((corePoweredUp && !stickyPowerdown && osLockSet)
			? OUT_OK : OUT_UNP))
		else $error("save restore outcome wrong");

	no_ossr_a: assert property (
		reqTaken and (!ctrl[CTL_OSSR] && pathOk && osLockSet && corePoweredUp
		&& offs == OFS_OS_LOCK_ACCESS_REG)
		|=> respOutcome == OUT_UNP)
		else $error("lock access not reserved without save restore");

	npossible_a: assert property (
		reqTaken and (ctrl[CTL_SINGLE] && !corePoweredUp)
		|=> respOutcome == OUT_NPOSS && !respSlvErr && !respForward)
		else $error("single domain powered down access answered");

	single_sticky_a: assert property (
		reqTaken and (ctrl[CTL_SINGLE] && corePoweredUp && stickyPowerdown
		&& !osLockSet && pathOk && cls == CLS_OTHER)
		|=> respOutcome == OUT_OK)
		else $error("sticky flag used in single domain");

	single_lock_a: assert property (
		reqTaken and (ctrl[CTL_SINGLE] && corePoweredUp && osLockSet && pathOk
		&& cls == CLS_OTHER)
		|=> respSlvErr)
		else $error("locked single domain access not errored");

	hidden_view_a: assert property (
		reqTaken and (cls == CLS_NOACC)
		|=> !respForward && !respWriteEn && status[EV_NOACC])
		else $error("hidden register reached");

	error_drop_a: assert property (
		respSlvErr |-> !respWriteEn && !respForward && respValid)
		else $error("error answer let write through");

	ig_quiet_a: assert property (
		respOutcome == OUT_IGABT && respValid |-> !respForward && !respSlvErr)
		else $error("ignored access reached processor");

	latency_a: assert property (
		reqTaken |=> respValid)
		else $error("answer not in next cycle");

	err_irq_a: assert property (
		errFlagged ##1 ce |=> irq)
		else $error("error event did not raise interrupt");

	freeze_state_a: assert property (
		!ce |=> $stable(ctrl) && $stable(status) && $stable(mask) && $stable(irq))
		else $error("state moved while clock enable low");

	freeze_resp_a: assert property (
		!ce |=> $stable(respValid) && $stable(respOutcome) && $stable(regRdata))
		else $error("answer moved while clock enable low");

	resp_idle_a: assert property (
		ce && !dbgReq
		|=> !respValid && !respForward && !respSlvErr && !respAbort)
		else $error("answer without request");

	ro_write_a: assert property (
		reqTaken and (dbgWrite && decided == OUT_OK && dag_read_only(offs))
		|=> respForward && !respWriteEn)
		else $error("read-only location written");

	razwi_read_a: assert property (
		reqTaken and (!dbgWrite && decided == OUT_RAZWI)
		|=> respReadZero && !respWriteEn && !respSlvErr)
		else $error("reserved read not zeroed");

	abort_sel_a: assert property (
		reqTaken and (decided == OUT_IGABT && ctrl[CTL_ABORT])
		|=> respAbort && !respForward)
		else $error("ignored access not aborted");

	quiet_drop_a: assert property (
		reqTaken and (decided == OUT_IGABT && !ctrl[CTL_ABORT])
		|=> !respAbort && !respForward && !respSlvErr)
		else $error("ignored access not dropped silently");

	split_ok_a: assert property (
		reqTaken and (sepPwr && pathOk && cls inside {CLS_ALWAYS, CLS_OS_LOCK_STATUS_REG, CLS_PWRCTL})
		|=> respForward && respOutcome == OUT_OK)
		else $error("always-open register blocked");

	lock_access_a: assert property (
		reqTaken and (sepPwr && pathOk && cls == CLS_OS_LOCK_ACCESS_REG)
		|=> respOutcome == (corePoweredUp ? OUT_OK : OUT_UNP))
		else $error("lock access outcome wrong");

	single_ok_a: assert property (
		reqTaken and (ctrl[CTL_SINGLE] && corePoweredUp && pathOk
		&& cls inside {CLS_ALWAYS, CLS_OS_LOCK_STATUS_REG, CLS_PWRCTL, CLS_OS_LOCK_ACCESS_REG, CLS_MGMT})
		|=> respForward)
		else $error("single domain open register blocked");

	single_rsvd_a: assert property (
		reqTaken and (ctrl[CTL_SINGLE] && corePoweredUp && pathOk && cls == CLS_RSVD)
		|=> respOutcome == (osLockSet ? OUT_UNP : OUT_RAZWI))
		else $error("single domain reserved outcome wrong");

	mm_gate_a: assert property (
		reqTaken and (ctrl[CTL_MEMMAP] && !isExt && !(dbgSwEnable && dbgPrivileged)
		&& !(ctrl[CTL_SINGLE] && !corePoweredUp))
		|=> respOutcome == OUT_IGABT)
		else $error("unqualified memory-mapped access proceeded");

	unp_event_a: assert property (
		reqTaken and (decided == OUT_UNP)
		|=> status[EV_UNP])
		else $error("unpredictable access not flagged");

endmodule

`default_nettype wire

// ===== core/dag_outcome_decode.sv
// Combinational permission decision for one debug register access.
// Assumes all condition inputs are stable and synchronous to the gate clock.

`default_nettype none

module dag_outcome_decode (
	input  wire logic [dag_pkg::ADDR_W-1:0] addr,
	input  wire logic                       isExt,
	input  wire logic                       swEnable,
	input  wire logic                       privileged,
	input  wire logic                       dbgLogicPowered,
	input  wire logic                       corePoweredUp,
	input  wire logic                       stickyPowerdown,
	input  wire logic                       osLockSet,
	input  wire logic                       memMapPresent,
	input  wire logic                       singlePower,
	input  wire logic                       osSaveRestore,
	output dag_pkg::dag_outcome_t           outcome,
	output dag_pkg::dag_class_t             cls
);
	import dag_pkg::*;

	logic extAccess;
	logic sticky;
	logic pwrClear;

	always_comb begin
		cls = dag_classify(addr);
		// Lock registers fall back to reserved without save/restore support
		if (!osSaveRestore && (cls == CLS_OS_LOCK_STATUS_REG || cls == CLS_OS_LOCK_ACCESS_REG || cls == CLS_OS_SAVE_RESTORE_REG))
			cls = CLS_RSVD;
		extAccess = !memMapPresent || isExt;
		sticky    = stickyPowerdown && !singlePower;
		pwrClear  = corePoweredUp && !sticky;
		outcome   = OUT_OK;
		if (singlePower && !corePoweredUp) begin
			outcome = OUT_NPOSS;
		end else if (!dbgLogicPowered) begin
			outcome = OUT_IGABT;
		end else if (!extAccess && !(swEnable && privileged)) begin
			outcome = OUT_IGABT;
		end else begin
			case (cls)
				CLS_ALWAYS, CLS_OS_LOCK_STATUS_REG, CLS_PWRCTL, CLS_MGMT: outcome = OUT_OK;
				CLS_OS_LOCK_ACCESS_REG: outcome = corePoweredUp ? OUT_OK : OUT_UNP;
				CLS_OS_SAVE_RESTORE_REG: outcome = (pwrClear && osLockSet) ? OUT_OK : OUT_UNP;
				CLS_OTHER: outcome = (pwrClear && !osLockSet) ? OUT_OK : OUT_ERROR;
				CLS_RSVD:  outcome = (pwrClear && !osLockSet) ? OUT_RAZWI : OUT_UNP;
				CLS_NOACC: outcome = OUT_IGABT;
				default:   outcome = OUT_UNP;
			endcase
		end
	end

endmodule

`default_nettype wire

// ===== core/dag_pkg.sv
// Constants, types and address decoding shared by the debug register access gate.
// Assumes a 12-bit word-aligned debug register map and one 40 MHz clock domain.

`default_nettype none

package dag_pkg;

	// ----------------------------------------------------------------
	// Debug register map
	// ----------------------------------------------------------------
	localparam int              ADDR_W       = 12;
	localparam int              PORT_W       = 32;
	localparam int              EXT_BIT      = 31;
	localparam logic [11:0]     OFS_ID       = 12'h000;
	localparam logic [11:0]     OFS_EVCATCH  = 12'h0A8;
	localparam logic [11:0]     OFS_RUNCTL   = 12'h090;
	localparam logic [11:0]     OFS_OS_LOCK_ACCESS_REG    = 12'h300;
	localparam logic [11:0]     OFS_OS_LOCK_STATUS_REG    = 12'h304;
	localparam logic [11:0]     OFS_OS_SAVE_RESTORE_REG    = 12'h308;
	localparam logic [11:0]     OFS_PDCTL    = 12'h310;
	localparam logic [11:0]     OFS_PDSTAT   = 12'h314;
	localparam logic [11:0]     OFS_ROMADDR  = 12'h200;
	localparam logic [11:0]     OFS_SELFADDR = 12'h204;
	localparam logic [11:0]     OFS_INTSTAT  = 12'h208;
	localparam logic [11:0]     OFS_INTRX    = 12'h20C;
	localparam logic [11:0]     OFS_INTTX    = 12'h210;
	localparam logic [11:0]     OTHER_HI     = 12'h1FC;
	localparam logic [11:0]     MGMT_LO      = 12'hD00;
	localparam logic [11:0]     MGMT_HI      = 12'hFFC;
	localparam logic [11:0]     IMPDEF_LO    = 12'hD00;
	localparam logic [11:0]     IMPDEF_HI    = 12'hDFC;

	// ----------------------------------------------------------------
	// Software register port
	// ----------------------------------------------------------------
	localparam int              REG_AW       = 4;
	localparam logic [3:0]      REG_CTRL     = 4'h0;
	localparam logic [3:0]      REG_STATUS   = 4'h4;
	localparam logic [3:0]      REG_MASK     = 4'h8;
	localparam logic [3:0]      REG_STATE    = 4'hC;
	localparam int              CTL_W        = 4;
	localparam int              CTL_MEMMAP   = 0;
	localparam int              CTL_SINGLE   = 1;
	localparam int              CTL_OSSR     = 2;
	localparam int              CTL_ABORT    = 3;
	localparam logic [3:0]      CTRL_RST     = 4'h5;
	localparam int              EV_N         = 4;
	localparam int              EV_ERROR     = 0;
	localparam int              EV_IGABT     = 1;
	localparam int              EV_UNP       = 2;
	localparam int              EV_NOACC     = 3;
	localparam logic [3:0]      STATUS_RST   = 4'h0;
	localparam logic [3:0]      MASK_RST     = 4'h0;
	localparam int              ST_OUT_LSB   = 4;

	typedef enum logic [2:0] {
		OUT_OK, OUT_RAZWI, OUT_ERROR, OUT_UNP, OUT_IGABT, OUT_NPOSS
	} dag_outcome_t;

	typedef enum logic [3:0] {
		CLS_ALWAYS, CLS_OS_LOCK_STATUS_REG, CLS_PWRCTL, CLS_OS_LOCK_ACCESS_REG, CLS_OS_SAVE_RESTORE_REG,
		CLS_OTHER, CLS_MGMT, CLS_RSVD, CLS_NOACC
	} dag_class_t;

	// Address classification, shared by the decoder and the checks
	function automatic dag_class_t dag_classify(input logic [ADDR_W-1:0] a);
		dag_classify = CLS_RSVD;
		case (a)
			OFS_ID, OFS_EVCATCH, OFS_RUNCTL: dag_classify = CLS_ALWAYS;
			OFS_OS_LOCK_STATUS_REG:                       dag_classify = CLS_OS_LOCK_STATUS_REG;
			OFS_PDCTL, OFS_PDSTAT:           dag_classify = CLS_PWRCTL;
			OFS_OS_LOCK_ACCESS_REG:                       dag_classify = CLS_OS_LOCK_ACCESS_REG;
			OFS_OS_SAVE_RESTORE_REG:                       dag_classify = CLS_OS_SAVE_RESTORE_REG;
			OFS_ROMADDR, OFS_SELFADDR,
			OFS_INTSTAT, OFS_INTRX, OFS_INTTX: dag_classify = CLS_NOACC;
			default: begin
				if (a <= OTHER_HI)
					dag_classify = CLS_OTHER;
				else if (a >= IMPDEF_LO && a <= IMPDEF_HI)
					dag_classify = CLS_RSVD;
				else if (a >= MGMT_LO && a <= MGMT_HI)
					dag_classify = CLS_MGMT;
			end
		endcase
	endfunction

	function automatic logic dag_read_only(input logic [ADDR_W-1:0] a);
		dag_read_only = (a == OFS_ID) || (a == OFS_OS_LOCK_STATUS_REG) || (a == OFS_PDSTAT);
	endfunction

endpackage

`default_nettype wire

// ===== sim/dag_gate_tb.sv
// Self-checking bench for the debug register access gate.
// Assumes one 40 MHz clock and a requester model on the debug side.
`default_nettype none

module dag_gate_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import dag_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic ref_clk, rst, ce, regWr, regRd, irq, go, goExt, goWr, dbgReq, dbgWrite;
	logic [3:0] regAddr, ctrl;
	logic [31:0] regWdata, regRdata, debugPortAddress;
	logic [11:0] goAddr;
	logic dbgSwEnable, dbgPrivileged, dbgLogicPowered, corePoweredUp;
	logic stickyPowerdown, osLockSet, respValid, respSlvErr, respAbort;
	logic respForward, respWriteEn, respReadZero;
	dag_outcome_t respOutcome;
	int error_cnt, tests_run;
	localparam logic [11:0] ADDRS [19] = '{12'h000, 12'h090, 12'h0A8, 12'h100, 12'h1FC,
		12'hE00, 12'hFFC, 12'hD80, 12'h400, 12'h300, 12'h304, 12'h308, 12'h310,
		12'h314, 12'h200, 12'h204, 12'h208, 12'h20C, 12'h210};
	localparam logic [3:0] CFGS [5] = '{4'h5, 4'h7, 4'h1, 4'hC, 4'hA};

	initial ref_clk = 1'b0;
	always #12.5 ref_clk = ~ref_clk;

	dag_gate dut_u (.ref_clk(ref_clk), .rst(rst), .ce(ce), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.dbgReq(dbgReq), .debugPortAddress(debugPortAddress), .dbgWrite(dbgWrite),
		.dbgSwEnable(dbgSwEnable), .dbgPrivileged(dbgPrivileged),
		.dbgLogicPowered(dbgLogicPowered), .corePoweredUp(corePoweredUp),
		.stickyPowerdown(stickyPowerdown), .osLockSet(osLockSet),
		.respValid(respValid), .respOutcome(respOutcome), .respSlvErr(respSlvErr),
		.respAbort(respAbort), .respForward(respForward), .respWriteEn(respWriteEn),
		.respReadZero(respReadZero), .irq(irq));

	dag_requester req_u (.clk(ref_clk), .rst(rst), .go(go), .goExt(goExt), .goWr(goWr),
		.goAddr(goAddr), .dbgReq(dbgReq), .debugPortAddress(debugPortAddress),
		.dbgWrite(dbgWrite));

	// ------------------------------------------------------------
	// Checking and reporting
	// ------------------------------------------------------------
	task automatic close_out;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic fail(input string msg);
		$display("[ERR] %0t %s", $time, msg);
		error_cnt++;
	endtask

	task automatic cmp_out(input dag_outcome_t g, input dag_outcome_t e);
		tests_run++;
		if (g !== e)
			fail("outcome mismatch");
	endtask

	task automatic cmp_bit(input logic g, input logic e);
		tests_run++;
		if (g !== e)
			fail("flag mismatch");
	endtask

	task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
			fail("register mismatch");
	endtask

	// ------------------------------------------------------------
	// Expected outcome, worked out from the permission tables
	// ------------------------------------------------------------
	// k = {logic powered, core up, sticky, lock, ext, sw enable, privileged}
	function automatic dag_outcome_t exp_out(input logic [3:0] c, input logic [6:0] k,
		input logic [11:0] a);
		logic sg, clr;
		sg = c[CTL_SINGLE];
		clr = k[5] && !(k[4] && !sg) && !k[3];
		if (sg && !k[5])
			return OUT_NPOSS;
		if (!k[6])
			return OUT_IGABT;
		if (c[CTL_MEMMAP] && !k[2] && !(k[1] && k[0]))
			return OUT_IGABT;
		if (a inside {OFS_ROMADDR, OFS_SELFADDR, OFS_INTSTAT, OFS_INTRX, OFS_INTTX})
			return OUT_IGABT;
		if (!c[CTL_OSSR] && a inside {OFS_OS_LOCK_ACCESS_REG, OFS_OS_LOCK_STATUS_REG, OFS_OS_SAVE_RESTORE_REG})
			return clr ? OUT_RAZWI : OUT_UNP;
		if (a inside {OFS_ID, OFS_EVCATCH, OFS_RUNCTL, OFS_OS_LOCK_STATUS_REG, OFS_PDCTL, OFS_PDSTAT})
			return OUT_OK;
		if (a == OFS_OS_LOCK_ACCESS_REG)
			return k[5] ? OUT_OK : OUT_UNP;
		if (a == OFS_OS_SAVE_RESTORE_REG)
			return (k[5] && !(k[4] && !sg) && k[3]) ? OUT_OK : OUT_UNP;
		if (a <= OTHER_HI)
			return clr ? OUT_OK : OUT_ERROR;
		if (a >= 12'hE00)
			return OUT_OK;
		return clr ? OUT_RAZWI : OUT_UNP;
	endfunction

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		cmp_reg(regRdata, e);
	endtask

	task automatic access(input logic [6:0] k, input logic [11:0] a, input logic wr);
		dag_outcome_t e;
		logic ro;
		int n;
		e = exp_out(ctrl, k, a);
		ro = (a == OFS_ID) || (a == OFS_OS_LOCK_STATUS_REG) || (a == OFS_PDSTAT);
		n = 0;
		@(posedge ref_clk);
		{dbgLogicPowered, corePoweredUp, stickyPowerdown, osLockSet} <= k[6:3];
		{goExt, dbgSwEnable, dbgPrivileged} <= k[2:0];
		go <= 1'b1;
		goAddr <= a;
		goWr <= wr;
		@(posedge ref_clk);
		go <= 1'b0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (respValid !== 1'b1 && n < 4);
		if (respValid !== 1'b1) begin
			fail("no response");
			close_out();
		end else begin
			cmp_bit(n == 1, 1'b1);
			cmp_out(respOutcome, e);
			cmp_bit(respSlvErr, e == OUT_ERROR);
			cmp_bit(respForward, e == OUT_OK);
			cmp_bit(respWriteEn, e == OUT_OK && wr && !ro);
			cmp_bit(respReadZero, e == OUT_RAZWI && !wr);
			cmp_bit(respAbort, e == OUT_IGABT && ctrl[CTL_ABORT]);
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rst, ce} = 2'b11;
		{regWr, regRd, go, goExt, goWr} = 5'h0;
		{regAddr, regWdata, goAddr, ctrl} = '0;
		{dbgSwEnable, dbgPrivileged, dbgLogicPowered, corePoweredUp} = 4'h0;
		{stickyPowerdown, osLockSet} = 2'h0;
		{error_cnt, tests_run} = 0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		reg_rd(REG_CTRL, 32'h5);
		reg_rd(REG_STATUS, 32'h0);
		reg_rd(REG_MASK, 32'h0);
		reg_rd(4'h2, 32'h0);
		// Every condition mix against every address class, per configuration
		foreach (CFGS[i]) begin
			ctrl = CFGS[i];
			reg_wr(REG_CTRL, {28'h0, ctrl});
			for (int k = 0; k < 128; k++)
				for (int j = 0; j < 19; j++)
					access(k[6:0], ADDRS[j], k[0] ^ j[0]);
		end
		// Error event raises the interrupt only while unmasked
		ctrl = 4'h5;
		reg_wr(REG_CTRL, 32'h5);
		reg_wr(REG_STATUS, 32'hF);
		reg_wr(REG_MASK, 32'h1);
		reg_rd(REG_STATUS, 32'h0);
		cmp_bit(irq, 1'b0);
		access(7'h7F, 12'h100, 1'b0);
		@(posedge ref_clk);
		#1;
		cmp_bit(irq, 1'b1);
		reg_rd(REG_STATUS, 32'h1);
		reg_wr(REG_MASK, 32'h0);
		@(posedge ref_clk);
		#1;
		cmp_bit(irq, 1'b0);
		reg_wr(REG_MASK, 32'h1);
		reg_wr(REG_STATUS, 32'h1);
		reg_rd(REG_STATUS, 32'h0);
		cmp_bit(irq, 1'b0);
		// Hidden and unpredictable accesses leave their own sticky bits
		access(7'h7F, OFS_ROMADDR, 1'b0);
		reg_rd(REG_STATUS, 32'hA);
		access(7'h7F, OFS_OS_SAVE_RESTORE_REG, 1'b0);
		reg_rd(REG_STATUS, 32'hE);
		reg_rd(REG_STATE, 32'h3F);
		// Clock enable low swallows a write
		@(posedge ref_clk);
		ce <= 1'b0;
		reg_wr(REG_MASK, 32'h0);
		ce <= 1'b1;
		reg_rd(REG_MASK, 32'h1);
		cmp_bit(irq, 1'b0);
		close_out();
	end
endmodule

`default_nettype wire

// ===== sim/dag_requester.sv
// Far-side model: debug access port issuing one-cycle register requests.
// Assumes commands arrive on the tb clock; the address bus toggles while idle.
`default_nettype none

module dag_requester (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        go,
	input  wire logic        goExt,
	input  wire logic        goWr,
	input  wire logic [11:0] goAddr,
	output logic             dbgReq,
	output logic [31:0]      debugPortAddress,
	output logic             dbgWrite
);
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// Request driver
	// ------------------------------------------------------------
	// Idle bus shows a changing pattern so stale values never pass as valid
	always_ff @(posedge clk) begin
		if (rst) begin
			dbgReq <= 1'b0;
			debugPortAddress <= 32'h0;
			dbgWrite <= 1'b0;
		end else begin
			dbgReq <= go;
			if (go) begin
				debugPortAddress <= {goExt, 19'h0, goAddr};
				dbgWrite <= goWr;
			end else begin
				debugPortAddress <= ~debugPortAddress;
				dbgWrite <= ~dbgWrite;
			end
		end
	end
endmodule

`default_nettype wire
